/* File: hdl/suspend_wake_pkg.sv */
// Constants, types and decode functions of the suspend and wake controller
package suspend_wake_pkg;

   // ----------------------------------------------------------------
   // Suspend select field codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SEL_WOL = 2'h0;
   localparam logic [1:0] SEL_WOL_ALT = 2'h1;
   localparam logic [1:0] SEL_DEEP = 2'h2;
   localparam logic [1:0] SEL_FULL = 2'h3;
   localparam logic [1:0] SEL_DEFAULT = SEL_DEEP;

   // ----------------------------------------------------------------
   // Wake event vector layout
   // ----------------------------------------------------------------
   localparam int GPIO_WIDTH = 11;
   localparam int EVENT_COUNT = 12;
   localparam int EV_RESUME = 0;
   localparam int EV_VBUS = 1;
   localparam int EV_MAGIC = 2;
   localparam int EV_WAKE_FRAME = 3;
   localparam int EV_BROADCAST = 4;
   localparam int EV_PERFECT_DA = 5;
   localparam int EV_GOOD_FRAME = 6;
   localparam int EV_TCP_SYN = 7;
   localparam int EV_EEE_RX = 8;
   localparam int EV_EEE_TX = 9;
   localparam int EV_PHY_LINK = 10;
   localparam int EV_GPIO = 11;

   // ----------------------------------------------------------------
   // Accepted wake events per power state
   // ----------------------------------------------------------------
   localparam logic [11:0] MASK_FULL = 12'hFFD;
   localparam logic [11:0] MASK_WOL = 12'hFBD;
   localparam logic [11:0] MASK_DEEP = 12'h801;
   localparam logic [11:0] MASK_UNPOWERED = 12'h002;
   localparam logic [11:0] MASK_PME = 12'hC3C;
   localparam logic [11:0] MASK_DETACH = 12'hC00;
   localparam logic [11:0] MASK_NONE = 12'h000;

   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_UNPOWERED = 3'h0,
      ST_NORMAL_UNCONF = 3'h1,
      ST_NORMAL_CONF = 3'h2,
      ST_SUSP_WOL = 3'h3,
      ST_SUSP_DEEP = 3'h4,
      ST_SUSP_FULL = 3'h5,
      ST_DETACHED = 3'h6,
      ST_WAKING = 3'h7
   } power_state_type;

   typedef struct packed {
      power_state_type state;
      logic configured;
      logic store;
      logic detach_ret;
      logic hs_wake;
      logic ss_wake;
      logic susp_n;
      logic fifo_wr;
      logic link_ret;
      logic afe_off;
      logic pll_en;
      logic attached;
   } ctl_type;

   function automatic logic [EVENT_COUNT-1:0] wake_mask(input power_state_type s,
                                                        input logic pme);
      unique case (s)
         ST_SUSP_WOL: wake_mask = pme ? MASK_PME : MASK_WOL;
         ST_SUSP_FULL: wake_mask = pme ? MASK_PME : MASK_FULL;
         ST_SUSP_DEEP: wake_mask = MASK_DEEP;
         ST_UNPOWERED: wake_mask = MASK_UNPOWERED;
         ST_DETACHED: wake_mask = MASK_DETACH;
         ST_NORMAL_UNCONF, ST_NORMAL_CONF, ST_WAKING: wake_mask = MASK_NONE;
      endcase
   endfunction

   function automatic logic is_suspend(input power_state_type s);
      is_suspend = (s == ST_SUSP_WOL) || (s == ST_SUSP_DEEP) || (s == ST_SUSP_FULL);
   endfunction

   function automatic logic is_normal(input power_state_type s);
      is_normal = (s == ST_NORMAL_UNCONF) || (s == ST_NORMAL_CONF);
   endfunction

endpackage

/* File: hdl/sticky_flags.sv */
// Bank of sticky flags, set by hardware events and cleared by software
`timescale 1ns/1ns
`default_nettype none

module sticky_flags #(
   parameter int WIDTH = 11
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Events and clears
   input wire logic [WIDTH-1:0] i_set,
   input wire logic [WIDTH-1:0] i_clear,
   // Flag state
   output logic [WIDTH-1:0] o_flags
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } flag_state_type;

   flag_state_type s_q;
   flag_state_type s_d;

   if (WIDTH < 1) begin : g_check
      $error("sticky_flags needs WIDTH of at least 1");
   end

   // A set arriving with its clear wins so no event is lost
   always_comb begin
      s_d = s_q;
      s_d.flags = (s_q.flags & ~i_clear) | i_set;
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_flags = s_q.flags;

   set_wins_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_set != '0) |=> ((o_flags & $past(i_set)) == $past(i_set)))
      else $error("Sticky flag lost an event");

   hold_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_clear == '0) |=> ((o_flags & $past(o_flags)) == $past(o_flags)))
      else $error("Sticky flag dropped without a clear");

endmodule

`default_nettype wire

/* File: hdl/suspend_wake_controller.sv */
// Power state sequencing and wake event handling of the bridge
`timescale 1ns/1ns
`default_nettype none

module suspend_wake_controller
   import suspend_wake_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // USB side status
   input wire logic i_usb_reset,
   input wire logic i_vbus_detect,
   input wire logic i_host_configured,
   input wire logic i_link_suspend,
   input wire logic i_host_resume,
   input wire logic i_superspeed,
   input wire logic i_remote_wake_allowed,
   input wire logic i_link_low_power,
   input wire logic i_traffic_pending,
   // Configuration
   input wire logic [1:0] i_suspend_select,
   input wire logic i_power_event_mode,
   input wire logic i_detach_on_link_loss_enable,
   input wire logic i_filter_wake_frame_flag,
   input wire logic i_eee_receive_wake_enable,
   input wire logic i_release_pin_on_wake,
   // Wake events
   input wire logic i_magic_packet,
   input wire logic i_wake_frame,
   input wire logic i_broadcast_frame,
   input wire logic i_perfect_da_match,
   input wire logic i_tcp_syn,
   input wire logic i_eee_receive_wake_flag,
   input wire logic i_eee_transmit_wake_flag,
   input wire logic i_phy_link_change,
   input wire logic [GPIO_WIDTH-1:0] i_gpio_wake,
   // Received frame status
   input wire logic i_frame_valid,
   input wire logic i_frame_error,
   input wire logic i_frame_pass_filter,
   // Software clears
   input wire logic [GPIO_WIDTH-1:0] i_clear_interrupt_flags,
   input wire logic [EVENT_COUNT-1:0] i_clear_wake_source,
   input wire logic i_clear_detach_return,
   // Power control
   output logic [2:0] o_power_state,
   output logic o_pll_enable,
   output logic o_afe_power_down,
   output logic o_usb_attached,
   // Wake signalling
   output logic o_hs_remote_wake,
   output logic o_ss_function_wake,
   output logic o_suspend_indicator_n,
   output logic o_link_return_request,
   // Receive storage and status
   output logic o_fifo_write_enable,
   output logic o_detach_return_flag,
   output logic [GPIO_WIDTH-1:0] o_interrupt_flags,
   output logic [EVENT_COUNT-1:0] o_wake_source
);

   ctl_type c_q;
   ctl_type c_d;
   logic [EVENT_COUNT-1:0] events;
   logic [EVENT_COUNT-1:0] accepted;
   logic [EVENT_COUNT-1:0] source_set;
   logic frame_ok;
   logic wake_hit;
   logic enter_waking;

   // ----------------------------------------------------------------
   // Sticky event flags
   // ----------------------------------------------------------------
   sticky_flags #(
      .WIDTH(GPIO_WIDTH)
   ) u_gpio_flags (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_set(i_gpio_wake),
      .i_clear(i_clear_interrupt_flags),
      .o_flags(o_interrupt_flags)
   );

   sticky_flags #(
      .WIDTH(EVENT_COUNT)
   ) u_wake_source (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_set(source_set),
      .i_clear(i_clear_wake_source),
      .o_flags(o_wake_source)
   );

   // ----------------------------------------------------------------
   // Wake event qualification
   // ----------------------------------------------------------------
   always_comb begin
      frame_ok = i_frame_valid & ~i_frame_error & i_frame_pass_filter;
      events = '0;
      events[EV_RESUME] = i_host_resume;
      events[EV_VBUS] = i_vbus_detect;
      events[EV_MAGIC] = i_magic_packet;
      events[EV_WAKE_FRAME] = i_wake_frame;
      events[EV_BROADCAST] = i_broadcast_frame;
      events[EV_PERFECT_DA] = i_perfect_da_match;
      events[EV_GOOD_FRAME] = i_filter_wake_frame_flag & frame_ok;
      events[EV_TCP_SYN] = i_tcp_syn;
      events[EV_EEE_RX] = i_eee_receive_wake_flag & i_eee_receive_wake_enable;
      events[EV_EEE_TX] = i_eee_transmit_wake_flag;
      events[EV_PHY_LINK] = i_phy_link_change;
      // Pending flags count too, so a stale GPIO wake rewakes at once
      events[EV_GPIO] = |(o_interrupt_flags | i_gpio_wake);
      // Per-state acceptance table
      accepted = events & wake_mask(c_q.state, i_power_event_mode);
      wake_hit = |(accepted & ~MASK_UNPOWERED);
      source_set = is_suspend(c_q.state) ? accepted : '0;
   end

   // ----------------------------------------------------------------
   // Power state sequencing
   // ----------------------------------------------------------------
   always_comb begin
      c_d = c_q;
      enter_waking = 1'b0;
      c_d.hs_wake = 1'b0;
      c_d.ss_wake = 1'b0;
      if (c_q.state == ST_DETACHED && wake_hit) begin
         c_d.detach_ret = 1'b1;
      end else if (i_clear_detach_return) begin
         c_d.detach_ret = 1'b0;
      end
      if (!i_vbus_detect) begin
         c_d.state = ST_UNPOWERED;
         c_d.configured = 1'b0;
         c_d.store = 1'b0;
      end else if (i_usb_reset) begin
         c_d.state = ST_NORMAL_UNCONF;
         c_d.configured = 1'b0;
         c_d.store = 1'b0;
      end else begin
         unique case (c_q.state)
            ST_UNPOWERED: begin
               if (accepted[EV_VBUS]) begin
                  c_d.state = ST_NORMAL_UNCONF;
               end
            end
            ST_NORMAL_UNCONF, ST_NORMAL_CONF: begin
               c_d.configured = i_host_configured;
               c_d.state = i_host_configured ? ST_NORMAL_CONF : ST_NORMAL_UNCONF;
               if (i_host_configured && i_detach_on_link_loss_enable) begin
                  c_d.state = ST_DETACHED;
               end else if (i_link_suspend) begin
                  if (!i_host_configured) begin
                     c_d.state = ST_SUSP_DEEP;
                  end else begin
                     unique case (i_suspend_select)
                        SEL_FULL: c_d.state = ST_SUSP_FULL;
                        SEL_DEEP: c_d.state = ST_SUSP_DEEP;
                        SEL_WOL, SEL_WOL_ALT: c_d.state = ST_SUSP_WOL;
                     endcase
                  end
               end
            end
            ST_SUSP_WOL, ST_SUSP_DEEP, ST_SUSP_FULL: begin
               if (accepted[EV_RESUME]) begin
                  c_d.state = c_q.configured ? ST_NORMAL_CONF : ST_NORMAL_UNCONF;
               end else if (wake_hit) begin
                  c_d.state = ST_WAKING;
                  enter_waking = 1'b1;
                  c_d.store = (c_q.state == ST_SUSP_FULL);
               end
            end
            ST_WAKING: begin
               if (i_host_resume) begin
                  c_d.state = c_q.configured ? ST_NORMAL_CONF : ST_NORMAL_UNCONF;
                  c_d.store = 1'b0;
               end
            end
            ST_DETACHED: begin
               if (wake_hit) begin
                  c_d.state = ST_NORMAL_UNCONF;
                  c_d.configured = 1'b0;
               end
            end
         endcase
      end
      c_d.hs_wake = enter_waking & i_remote_wake_allowed & ~i_superspeed;
      c_d.ss_wake = enter_waking & i_remote_wake_allowed & i_superspeed;
      c_d.susp_n = is_normal(c_d.state)
         | ((c_d.state == ST_WAKING) & i_release_pin_on_wake);
      // Trigger frame first, then every passing frame until resume
      c_d.fifo_wr = frame_ok & ((enter_waking & c_d.store)
         | ((c_q.state == ST_WAKING) & c_q.store & c_d.store));
      c_d.link_ret = is_normal(c_q.state) & i_link_low_power & i_traffic_pending;
      // Front ends sleep in suspend and while detached; both come back together
      c_d.afe_off = is_suspend(c_d.state) | (c_d.state == ST_DETACHED)
         | (c_d.state == ST_UNPOWERED);
      // Reference clock stays with MAC and PHY; only the PLLs stop
      c_d.pll_en = ~((c_d.state == ST_SUSP_WOL) | (c_d.state == ST_SUSP_DEEP)
         | (c_d.state == ST_DETACHED) | (c_d.state == ST_UNPOWERED));
      c_d.attached = (c_d.state != ST_DETACHED) & (c_d.state != ST_UNPOWERED);
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         c_q.state <= ST_NORMAL_UNCONF;
         c_q.configured <= 1'b0;
         c_q.store <= 1'b0;
         c_q.detach_ret <= 1'b0;
         c_q.hs_wake <= 1'b0;
         c_q.ss_wake <= 1'b0;
         c_q.susp_n <= 1'b1;
         c_q.fifo_wr <= 1'b0;
         c_q.link_ret <= 1'b0;
         c_q.afe_off <= 1'b0;
         c_q.pll_en <= 1'b1;
         c_q.attached <= 1'b1;
      end else begin
         c_q <= c_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_power_state = c_q.state;
   assign o_pll_enable = c_q.pll_en;
   assign o_afe_power_down = c_q.afe_off;
   assign o_usb_attached = c_q.attached;
   assign o_hs_remote_wake = c_q.hs_wake;
   assign o_ss_function_wake = c_q.ss_wake;
   assign o_suspend_indicator_n = c_q.susp_n;
   assign o_link_return_request = c_q.link_ret;
   assign o_fifo_write_enable = c_q.fifo_wr;
   assign o_detach_return_flag = c_q.detach_ret;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   sequence detach_request;
      (c_q.state == ST_NORMAL_CONF) && i_host_configured && i_detach_on_link_loss_enable
         && i_vbus_detect && !i_usb_reset;
   endsequence

   sequence detach_taken;
      (c_q.state == ST_DETACHED) && !o_usb_attached && !o_pll_enable;
   endsequence

   full_select_a: assert property (
      (c_q.state == ST_NORMAL_CONF) && i_host_configured && i_link_suspend
      && !i_detach_on_link_loss_enable && (i_suspend_select == SEL_FULL)
      && i_vbus_detect && !i_usb_reset |=> (c_q.state == ST_SUSP_FULL) && o_pll_enable)
      else $error("Full-clock suspend not entered");

   full_afe_a: assert property (
      (c_q.state == ST_SUSP_FULL) |-> o_afe_power_down && o_pll_enable)
      else $error("Full-clock suspend power setting wrong");

   eee_exit_a: assert property (
      (c_q.state == ST_SUSP_FULL) && !i_power_event_mode && i_eee_transmit_wake_flag
      && !i_host_resume && i_vbus_detect && !i_usb_reset |=> (c_q.state == ST_WAKING))
      else $error("EEE transmit wake ignored");

   fifo_gate_a: assert property (
      o_fifo_write_enable |-> $past(c_q.state == ST_SUSP_FULL || c_q.state == ST_WAKING))
      else $error("Frame stored outside full-clock wake");

   detach_entry_a: assert property (
      detach_request |=> detach_taken)
      else $error("Detach not carried out");

   detach_return_a: assert property (
      (c_q.state == ST_DETACHED) ##1 (c_q.state == ST_NORMAL_UNCONF)
      |-> o_detach_return_flag && o_usb_attached && !o_afe_power_down)
      else $error("Return from detach not flagged");

   deep_ignore_a: assert property (
      (c_q.state == ST_SUSP_DEEP) && !i_host_resume && (i_gpio_wake == '0)
      && (o_interrupt_flags == '0) && i_vbus_detect && !i_usb_reset
      |=> (c_q.state == ST_SUSP_DEEP))
      else $error("Deep suspend left on a masked event");

   gpio_rewake_a: assert property (
      is_suspend(c_q.state) && (o_interrupt_flags != '0) && !i_host_resume
      && i_vbus_detect && !i_usb_reset |=> (c_q.state == ST_WAKING))
      else $error("Pending GPIO flag did not rewake");

   remote_hs_a: assert property (
      $rose(c_q.state == ST_WAKING) && $past(i_remote_wake_allowed && !i_superspeed)
      |-> o_hs_remote_wake ##1 !o_hs_remote_wake)
      else $error("High-speed remote wake not a single pulse");

   usb_reset_a: assert property (
      i_usb_reset && i_vbus_detect |=> (c_q.state == ST_NORMAL_UNCONF) && !c_q.configured)
      else $error("USB reset did not reinitialize");

endmodule

`default_nettype wire

/* File: testbench/usb_host_model.sv */
// Behavioural USB host: suspends, resets and resumes the link, answers remote wake
`timescale 1ns/1ns
`default_nettype none

module usb_host_model #(
   parameter int RESUME_DELAY = 6
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Requests from the bench
   input wire logic i_suspend_request,
   input wire logic i_resume_request,
   input wire logic i_reset_request,
   // Device side
   input wire logic i_remote_wake,
   output logic o_link_suspend,
   output logic o_host_resume,
   output logic o_usb_reset,
   output logic o_configured,
   output logic o_remote_wake_allowed
);
   int count_q;

   // Resume is answered late on purpose so the waking state stays visible
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_link_suspend <= 1'h0;
         o_host_resume <= 1'h0;
         o_usb_reset <= 1'h0;
         o_configured <= 1'h0;
         o_remote_wake_allowed <= 1'h0;
         count_q <= 0;
      end else begin
         o_configured <= 1'h1;
         o_remote_wake_allowed <= 1'h1;
         o_host_resume <= 1'h0;
         o_usb_reset <= i_reset_request;
         if (i_reset_request) begin
            o_link_suspend <= 1'h0;
         end else if (i_suspend_request) begin
            o_link_suspend <= 1'h1;
         end
         if (i_remote_wake || i_resume_request) begin
            count_q <= RESUME_DELAY;
         end else if (count_q == 1) begin
            o_link_suspend <= 1'h0;
            o_host_resume <= 1'h1;
            count_q <= 0;
         end else if (count_q > 1) begin
            count_q <= count_q - 1;
         end
      end
   end
endmodule

`default_nettype wire

/* File: testbench/suspend_wake_controller_test.sv */
// Self-checking bench of the suspend and wake controller
`timescale 1ns/1ns
`default_nettype none

module suspend_wake_controller_test
   import suspend_wake_pkg::*;
;
   logic clock, resetn, vbus, low_power, traffic, pme, detach, valid, pass, err;
   logic sus_req, res_req, rst_req, clr_det, link_sus, resume, usb_rst, conf, allowed;
   logic pll, afe_down, attached, hs_wake, ss_wake, susp_n, link_ret, fifo_wr, det_ret;
   logic ss, eee_en, pin_rel, fwf;
   logic [1:0] sel;
   logic [2:0] state;
   logic [10:0] gpio, clr_int, int_flags;
   logic [11:0] ev, clr_src, src;
   int failures, comparisons, hs_count, ss_count, fifo_count;

   // ----------------------------------------------------------------
   // Accepted events per state, bit order of the wake source vector
   // ----------------------------------------------------------------
   localparam logic [11:0] EXP_FULL = 12'hFFD;
   localparam logic [11:0] EXP_WOL = 12'hFBD;
   localparam logic [11:0] EXP_DEEP = 12'h801;
   localparam logic [11:0] EXP_PME = 12'hC3C;

   usb_host_model usb_host_model_inst (.i_clock(clock), .i_resetn(resetn),
      .i_suspend_request(sus_req), .i_resume_request(res_req), .i_reset_request(rst_req),
      .i_remote_wake(hs_wake | ss_wake), .o_link_suspend(link_sus), .o_host_resume(resume),
      .o_usb_reset(usb_rst), .o_configured(conf), .o_remote_wake_allowed(allowed));

   suspend_wake_controller suspend_wake_controller_inst (.i_clock(clock), .i_resetn(resetn),
      .i_usb_reset(usb_rst), .i_vbus_detect(vbus), .i_host_configured(conf),
      .i_link_suspend(link_sus), .i_host_resume(resume), .i_superspeed(ss),
      .i_remote_wake_allowed(allowed), .i_link_low_power(low_power),
      .i_traffic_pending(traffic), .i_suspend_select(sel), .i_power_event_mode(pme),
      .i_detach_on_link_loss_enable(detach), .i_filter_wake_frame_flag(fwf),
      .i_eee_receive_wake_enable(eee_en), .i_release_pin_on_wake(pin_rel),
      .i_magic_packet(ev[EV_MAGIC]), .i_wake_frame(ev[EV_WAKE_FRAME]),
      .i_broadcast_frame(ev[EV_BROADCAST]), .i_perfect_da_match(ev[EV_PERFECT_DA]),
      .i_tcp_syn(ev[EV_TCP_SYN]), .i_eee_receive_wake_flag(ev[EV_EEE_RX]),
      .i_eee_transmit_wake_flag(ev[EV_EEE_TX]), .i_phy_link_change(ev[EV_PHY_LINK]),
      .i_gpio_wake(gpio), .i_frame_valid(valid), .i_frame_error(err),
      .i_frame_pass_filter(pass), .i_clear_interrupt_flags(clr_int),
      .i_clear_wake_source(clr_src), .i_clear_detach_return(clr_det),
      .o_power_state(state), .o_pll_enable(pll), .o_afe_power_down(afe_down),
      .o_usb_attached(attached), .o_hs_remote_wake(hs_wake), .o_ss_function_wake(ss_wake),
      .o_suspend_indicator_n(susp_n), .o_link_return_request(link_ret),
      .o_fifo_write_enable(fifo_wr), .o_detach_return_flag(det_ret),
      .o_interrupt_flags(int_flags), .o_wake_source(src));

   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end

   // One-cycle strobes are counted on the edge after they appear
   always @(posedge clock) begin
      if (hs_wake === 1'h1) hs_count++;
      if (ss_wake === 1'h1) ss_count++;
      if (fifo_wr === 1'h1) fifo_count++;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test;
      if (failures == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic wait_state(input logic [2:0] st);
      for (int n = 0; n < 60 && state !== st; n++) @(negedge clock);
      check("power state", state, st);
      if (state !== st) stop_test();
   endtask

   task automatic fire(input int idx);
      if (idx == EV_GOOD_FRAME) begin
         valid = 1'h1;
         pass = 1'h1;
      end else if (idx == EV_GPIO) gpio = 11'h400;
      else ev[idx] = 1'h1;
      @(negedge clock);
      valid = 1'h0;
      pass = 1'h0;
      gpio = 11'h000;
      ev = 12'h000;
   endtask

   task automatic go_suspend(input logic [1:0] s, input logic p);
      clr_int = 11'h7FF;
      clr_src = 12'hFFF;
      sel = s;
      pme = p;
      sus_req = 1'h1;
      @(negedge clock);
      clr_int = 11'h000;
      clr_src = 12'h000;
      sus_req = 1'h0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic wake_case(input logic [1:0] s, input logic p, input int idx,
                            input logic [11:0] acc, input logic [2:0] st);
      int h0;
      int f0;
      go_suspend(s, p);
      wait_state(st);
      h0 = hs_count;
      f0 = fifo_count;
      fire(idx);
      check("wake state", state, acc[idx] ? 3'(ST_WAKING) : st);
      check("wake source", src[idx], acc[idx]);
      if (!acc[idx]) begin
         res_req = 1'h1;
         @(negedge clock);
         res_req = 1'h0;
         repeat (8) @(negedge clock);
         // Power event mode ignores host resume, so only a bus reset brings it back
         if (!acc[EV_RESUME]) begin
            check("resume ignored", state, st);
            rst_req = 1'h1;
            @(negedge clock);
            rst_req = 1'h0;
         end
      end
      wait_state(ST_NORMAL_CONF);
      check("remote wakes", hs_count - h0, acc[idx]);
      if (s != SEL_FULL) check("fifo writes", fifo_count - f0, 0);
   endtask

   task automatic store_frames;
      int f0;
      f0 = fifo_count;
      // Host has its ARP and NS offloads on before a full-clock suspend
      go_suspend(SEL_FULL, 1'h0);
      wait_state(ST_SUSP_FULL);
      check("front ends off", afe_down, 1);
      check("clocks kept", pll, 1);
      fire(EV_GOOD_FRAME);
      valid = 1'h1;
      pass = 1'h1;
      err = 1'h1;
      @(negedge clock);
      err = 1'h0;
      @(negedge clock);
      valid = 1'h0;
      pass = 1'h0;
      wait_state(ST_NORMAL_CONF);
      check("fifo writes", fifo_count - f0, 2);
   endtask

   // Disabled wakes, superspeed function wake and indicator release
   task automatic option_case;
      int s0;
      int h0;
      s0 = ss_count;
      h0 = hs_count;
      {ss, eee_en, pin_rel, fwf} = 4'hA;
      go_suspend(SEL_FULL, 1'h0);
      wait_state(ST_SUSP_FULL);
      check("indicator low", susp_n, 0);
      fire(EV_EEE_RX);
      fire(EV_GOOD_FRAME);
      check("disabled wakes", state, ST_SUSP_FULL);
      fire(EV_EEE_TX);
      check("tx wake state", state, ST_WAKING);
      check("indicator released", susp_n, 1);
      wait_state(ST_NORMAL_CONF);
      check("function wakes", ss_count - s0, 1);
      check("hs wakes in ss", hs_count - h0, 0);
      {ss, eee_en, pin_rel, fwf} = 4'h5;
   endtask

   task automatic pending_gpio;
      fire(EV_GPIO);
      check("gpio flags", int_flags, 11'h400);
      sel = SEL_DEEP;
      sus_req = 1'h1;
      @(negedge clock);
      sus_req = 1'h0;
      wait_state(ST_WAKING);
      wait_state(ST_NORMAL_CONF);
      // A flag left pending would end the detached state at once
      clr_int = 11'h7FF;
      @(negedge clock);
      clr_int = 11'h000;
      check("gpio flags cleared", int_flags, 11'h000);
   endtask

   // Bench plays the driver that has already confirmed link loss
   task automatic detach_case;
      detach = 1'h1;
      wait_state(ST_DETACHED);
      detach = 1'h0;
      check("pll", pll, 0);
      check("attached", attached, 0);
      fire(EV_MAGIC);
      check("detached stays", state, ST_DETACHED);
      fire(EV_PHY_LINK);
      check("reattach state", state, ST_NORMAL_UNCONF);
      check("reattach", {pll, attached, afe_down}, 3'h6);
      check("detach return", det_ret, 1);
      clr_det = 1'h1;
      wait_state(ST_NORMAL_CONF);
      clr_det = 1'h0;
      check("detach flag cleared", det_ret, 0);
   endtask

   task automatic power_case;
      low_power = 1'h1;
      traffic = 1'h1;
      repeat (3) @(negedge clock);
      check("link return", link_ret, 1);
      low_power = 1'h0;
      traffic = 1'h0;
      go_suspend(SEL_FULL, 1'h0);
      wait_state(ST_SUSP_FULL);
      rst_req = 1'h1;
      @(negedge clock);
      rst_req = 1'h0;
      wait_state(ST_NORMAL_UNCONF);
      wait_state(ST_NORMAL_CONF);
      vbus = 1'h0;
      wait_state(ST_UNPOWERED);
      fire(EV_MAGIC);
      fire(EV_GPIO);
      check("unpowered stays", state, ST_UNPOWERED);
      vbus = 1'h1;
      wait_state(ST_NORMAL_UNCONF);
   endtask

   initial begin
      {resetn, low_power, traffic, pme, detach, valid, pass, err} = 8'h00;
      {sus_req, res_req, rst_req, clr_det} = 4'h0;
      {ss, eee_en, pin_rel, fwf} = 4'h5;
      vbus = 1'h1;
      sel = SEL_DEFAULT;
      gpio = 11'h000;
      clr_int = 11'h000;
      ev = 12'h000;
      clr_src = 12'h000;
      repeat (20) @(negedge clock);
      resetn = 1'h1;
      wait_state(ST_NORMAL_CONF);
      for (int i = 2; i < EVENT_COUNT; i++) begin
         wake_case(SEL_FULL, 1'h0, i, EXP_FULL, ST_SUSP_FULL);
         wake_case(SEL_WOL, 1'h0, i, EXP_WOL, ST_SUSP_WOL);
         wake_case(SEL_WOL_ALT, 1'h1, i, EXP_PME, ST_SUSP_WOL);
         wake_case(SEL_DEEP, 1'h0, i, EXP_DEEP, ST_SUSP_DEEP);
      end
      store_frames();
      option_case();
      pending_gpio();
      detach_case();
      power_case();
      stop_test();
   end
endmodule

`default_nettype wire
